// ==== pcic_consts.svh ====
`ifndef PCIC_CONSTS_SVH
`define PCIC_CONSTS_SVH

`define PCIC_PORT_W          8
`define PCIC_ADDR_W          8

`define PCIC_OFS_IRQ_ENABLE  8'h02
`define PCIC_OFS_REFERENCE   8'h03
`define PCIC_OFS_SOURCE_SEL  8'h04
`define PCIC_OFS_CONFIG      8'h05
`define PCIC_OFS_WEAK_BIAS   8'h06
`define PCIC_OFS_IRQ_FLAGS   8'h07
`define PCIC_OFS_CAPTURE     8'h08
`define PCIC_OFS_PORT        8'h09

`define PCIC_CFG_BIT_AUTOINC 5
`define PCIC_CFG_BIT_SDA     4
`define PCIC_CFG_BIT_ADDRPIN 3
`define PCIC_CFG_BIT_OD      2
`define PCIC_CFG_BIT_POL     1

`define PCIC_RST_BYTE        8'h00
`define PCIC_RST_CFG         5'h00

`endif

// ==== pcic_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module pcic_host_model (
    input  wire logic                    i_clk,
    output var  pcic_pkg::pcic_reg_req_s o_req
);
    initial o_req = '0;

    // One request per edge; an idle call drops the strobes
    task automatic xfer(input logic wr, input logic rd, input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        o_req <= '{wr: wr, rd: rd, addr: addr, wdata: data};
    endtask
endmodule

`default_nettype wire

// ==== pcic_pin_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pcic_consts.svh"

module pcic_pin_detect #(
    parameter int unsigned PINS = `PCIC_PORT_W
) (
    input  wire logic            i_clk,
    input  wire logic            i_sys_rst,
    input  wire logic [PINS-1:0] i_pin_level,
    input  wire logic [PINS-1:0] i_pin_is_input,
    input  wire logic [PINS-1:0] i_enable,
    input  wire logic [PINS-1:0] i_compare_select_bits,
    input  wire logic [PINS-1:0] i_reference_bits,
    output logic      [PINS-1:0] o_cond
);

    logic [PINS-1:0] prev;

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            logic armed;
            logic next_prev;

            always_comb begin
                armed     = i_enable[g] & i_pin_is_input[g];
                o_cond[g] = 1'b0;
                next_prev = i_pin_level[g];
                if (armed) begin
                    if (i_compare_select_bits[g]) begin
                        o_cond[g] = i_pin_level[g] ^ i_reference_bits[g];
                    end else begin
                        o_cond[g] = i_pin_level[g] ^ prev[g];
                        // Re-arm on the new level only when an event fires
                        next_prev = o_cond[g] ? i_pin_level[g] : prev[g];
                    end
                end
            end

            always_ff @(posedge i_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    prev[g] <= 1'b0;
                end else begin
                    prev[g] <= next_prev;
                end
            end

            prev_rearm_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
                (o_cond[g] && !i_compare_select_bits[g]) |=> (prev[g] == $past(i_pin_level[g])))
                else $error("previous-value reference not updated after event");
        end
    endgenerate

endmodule

`default_nettype wire

// ==== pcic_pkg.sv ====
`default_nettype none

package pcic_pkg;

    typedef struct packed {
        logic auto_increment_off;
        logic sda_edge_limit_off;
        logic address_pin_enable;
        logic open_drain_select;
        logic irq_polarity;
    } pcic_cfg_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcic_reg_req_s;

endpackage

`default_nettype wire

// ==== pcic_port_change_irq.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pcic_consts.svh"

// Operation
// - Enable bit 1 lets a pin raise change events; 0 blocks it.
// - Reference mode flags a pin whose level differs from its reference bit.
// - Select bit 1 compares to reference, 0 compares to previous level.
// - Enable, reference, select and bias bytes are read/write, zero at reset.
// - Config bit 5 set holds the address pointer; clear lets it advance.
// - Config bit 4 set disables SDA fall limiting; clear applies it.
// - Config bit 3 enables address pins on SPI variant; I2C always uses them.
// - Config bit 1 sets interrupt active level, only when not open-drain.
// - Bias bit enables weak pull-up only on pins set as inputs.
// - Flag bits show which enabled pins caused the interrupt.
// - Flag byte is read-only; writes to it are discarded.
// - While pending, new events set flags but leave the capture byte alone, except in a capture or port read cycle.
// - Interrupt holds until a capture or port read; writes do not clear.
// - Only input pins may generate events; outputs have no effect.
// - Previous-value mode re-arms on the new level after each event.
// - Reference mode condition persists while the mismatch lasts, even after reads.
module pcic_port_change_irq #(
    parameter bit IS_SPI = 1'b0
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_sys_rst,
    input  wire pcic_pkg::pcic_reg_req_s i_reg_req,
    input  wire logic [7:0]              i_pin_level,
    input  wire logic [7:0]              i_pin_is_input,
    output logic      [7:0]              o_reg_rdata,
    output logic                         o_reg_rvalid,
    output logic                         o_irq_out,
    output logic                         o_irq_oe_n,
    output logic      [7:0]              o_weak_pullup_en,
    output logic                         o_auto_increment_off,
    output logic                         o_sda_edge_limit_on,
    output logic                         o_address_pin_enable
);

    // Register file
    logic [7:0]          irq_enable;
    logic [7:0]          reference;
    logic [7:0]          source_sel;
    logic [7:0]          weak_bias;
    pcic_pkg::pcic_cfg_s cfg;
    logic [7:0]          next_irq_enable;
    logic [7:0]          next_reference;
    logic [7:0]          next_source_sel;
    logic [7:0]          next_weak_bias;
    pcic_pkg::pcic_cfg_s next_cfg;

    // Event state
    logic [7:0]          flags;
    logic [7:0]          capture;
    logic [7:0]          next_flags;
    logic [7:0]          next_capture;
    logic [7:0]          cond;
    logic                pending;
    logic                clr;

    // Output stage
    logic [7:0]          next_rdata;
    logic                next_rvalid;
    logic                next_irq_out;
    logic                next_irq_oe_n;
    logic [7:0]          next_pullup;
    logic [7:0]          cfg_byte;

    pcic_pin_detect #(
        .PINS (`PCIC_PORT_W)
    ) u_detect (
        .i_clk                 (i_clk),
        .i_sys_rst             (i_sys_rst),
        .i_pin_level           (i_pin_level),
        .i_pin_is_input        (i_pin_is_input),
        .i_enable              (irq_enable),
        .i_compare_select_bits (source_sel),
        .i_reference_bits      (reference),
        .o_cond                (cond)
    );

    always_comb begin
        cfg_byte = 8'h00;
        cfg_byte[`PCIC_CFG_BIT_AUTOINC] = cfg.auto_increment_off;
        cfg_byte[`PCIC_CFG_BIT_SDA]     = cfg.sda_edge_limit_off;
        cfg_byte[`PCIC_CFG_BIT_ADDRPIN] = cfg.address_pin_enable;
        cfg_byte[`PCIC_CFG_BIT_OD]      = cfg.open_drain_select;
        cfg_byte[`PCIC_CFG_BIT_POL]     = cfg.irq_polarity;
    end

    // Register writes
    always_comb begin
        next_irq_enable = irq_enable;
        next_reference  = reference;
        next_source_sel = source_sel;
        next_weak_bias  = weak_bias;
        next_cfg        = cfg;
        if (i_reg_req.wr) begin
            case (i_reg_req.addr)
                `PCIC_OFS_IRQ_ENABLE: begin
                    next_irq_enable = i_reg_req.wdata;
                end
                `PCIC_OFS_REFERENCE: begin
                    next_reference = i_reg_req.wdata;
                end
                `PCIC_OFS_SOURCE_SEL: begin
                    next_source_sel = i_reg_req.wdata;
                end
                `PCIC_OFS_WEAK_BIAS: begin
                    next_weak_bias = i_reg_req.wdata;
                end
                `PCIC_OFS_CONFIG: begin
                    // Unimplemented bits are simply not stored
                    next_cfg.auto_increment_off = i_reg_req.wdata[`PCIC_CFG_BIT_AUTOINC];
                    next_cfg.sda_edge_limit_off = i_reg_req.wdata[`PCIC_CFG_BIT_SDA];
                    next_cfg.address_pin_enable = i_reg_req.wdata[`PCIC_CFG_BIT_ADDRPIN];
                    next_cfg.open_drain_select  = i_reg_req.wdata[`PCIC_CFG_BIT_OD];
                    next_cfg.irq_polarity       = i_reg_req.wdata[`PCIC_CFG_BIT_POL];
                end
                default: begin
                    // Flag and capture writes are dropped here
                    next_cfg = cfg;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_enable <= `PCIC_RST_BYTE;
            reference  <= `PCIC_RST_BYTE;
            source_sel <= `PCIC_RST_BYTE;
            weak_bias  <= `PCIC_RST_BYTE;
            cfg        <= `PCIC_RST_CFG;
        end else begin
            irq_enable <= next_irq_enable;
            reference  <= next_reference;
            source_sel <= next_source_sel;
            weak_bias  <= next_weak_bias;
            cfg        <= next_cfg;
        end
    end

    // Flags and capture
    always_comb begin
        pending    = |flags;
        clr        = i_reg_req.rd &&
                     (i_reg_req.addr == `PCIC_OFS_CAPTURE || i_reg_req.addr == `PCIC_OFS_PORT);
        // New events win over a clearing read
        next_flags = (flags & ~{8{clr}}) | cond;
        next_capture = capture;
        if ((!pending || clr) && (|cond)) begin
            next_capture = i_pin_level;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            flags   <= `PCIC_RST_BYTE;
            capture <= `PCIC_RST_BYTE;
        end else begin
            flags   <= next_flags;
            capture <= next_capture;
        end
    end

    // Read data and pins
    always_comb begin
        next_rvalid = i_reg_req.rd;
        next_rdata  = o_reg_rdata;
        if (i_reg_req.rd) begin
            case (i_reg_req.addr)
                `PCIC_OFS_IRQ_ENABLE: next_rdata = irq_enable;
                `PCIC_OFS_REFERENCE:  next_rdata = reference;
                `PCIC_OFS_SOURCE_SEL: next_rdata = source_sel;
                `PCIC_OFS_CONFIG:     next_rdata = cfg_byte;
                `PCIC_OFS_WEAK_BIAS:  next_rdata = weak_bias;
                `PCIC_OFS_IRQ_FLAGS:  next_rdata = flags;
                `PCIC_OFS_CAPTURE:    next_rdata = capture;
                default:              next_rdata = 8'h00;
            endcase
        end
        if (cfg.open_drain_select) begin
            next_irq_out  = 1'b0;
            next_irq_oe_n = !pending;
        end else begin
            next_irq_out  = pending ? cfg.irq_polarity : !cfg.irq_polarity;
            next_irq_oe_n = 1'b0;
        end
        next_pullup = weak_bias & i_pin_is_input;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata      <= 8'h00;
            o_reg_rvalid     <= 1'b0;
            o_irq_out        <= 1'b0;
            o_irq_oe_n       <= 1'b1;
            o_weak_pullup_en <= 8'h00;
        end else begin
            o_reg_rdata      <= next_rdata;
            o_reg_rvalid     <= next_rvalid;
            o_irq_out        <= next_irq_out;
            o_irq_oe_n       <= next_irq_oe_n;
            o_weak_pullup_en <= next_pullup;
        end
    end

    assign o_auto_increment_off = cfg.auto_increment_off;
    assign o_sda_edge_limit_on  = !cfg.sda_edge_limit_off;
    assign o_address_pin_enable = IS_SPI ? cfg.address_pin_enable : 1'b1;

    enable_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (cond & ~irq_enable) == 8'h00)
        else $error("disabled pin raised an event");

    input_only_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (cond & ~i_pin_is_input) == 8'h00)
        else $error("output pin raised an event");

    ref_compare_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ((irq_enable & i_pin_is_input & source_sel) & (cond ^ (i_pin_level ^ reference))) == 8'h00)
        else $error("reference compare mismatch");

    flag_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ((flags & ~next_flags) != 8'h00) |-> clr)
        else $error("flag cleared without capture or port read");

    clear_reload_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        clr |=> (flags == $past(cond)))
        else $error("flags after clearing read do not match live condition");

    capture_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (pending && !clr) |=> $stable(capture))
        else $error("capture changed while interrupt pending");

    od_drive_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        1'b1 |=> (o_irq_oe_n == ($past(cfg.open_drain_select) && !$past(pending))))
        else $error("interrupt output enable wrong");

    polarity_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !cfg.open_drain_select |=> (o_irq_out == ($past(pending) == $past(cfg.irq_polarity))))
        else $error("driven interrupt level wrong");

    cfg_reserved_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_reg_req.rd && i_reg_req.addr == `PCIC_OFS_CONFIG) |=> ((o_reg_rdata & 8'hC1) == 8'h00))
        else $error("unimplemented config bits read nonzero");

    pullup_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        1'b1 |=> (o_weak_pullup_en == $past(weak_bias & i_pin_is_input)))
        else $error("pull-up enabled on non-input pin");

endmodule

`default_nettype wire

// ==== test_port_change_irq_config.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pcic_consts.svh"

module test_port_change_irq_config;
    logic                    i_clk;
    logic                    i_sys_rst;
    pcic_pkg::pcic_reg_req_s req;
    logic [7:0]              pin;
    logic [7:0]              inp;
    logic [7:0]              o_reg_rdata;
    logic                    o_reg_rvalid;
    logic                    o_irq_out;
    logic                    o_irq_oe_n;
    logic [7:0]              o_weak_pullup_en;
    logic                    o_auto_increment_off;
    logic                    o_sda_edge_limit_on;
    logic                    o_address_pin_enable;
    logic                    spi_addr_pin_en;
    logic [7:0]              m_en, m_ref, m_sel, m_bias, m_flags, m_cap, m_prev, m_rdata, m_pu, cond, upd;
    logic [4:0]              m_cfg;
    logic                    m_rv, m_iout, m_ioe, clr;
    logic [31:0]             seed;
    int                      miscompares, num_checks, cycles;

    // Ctl byte (02 write, 01 read), address, data, pin toggle mask
    localparam logic [31:0] DIR [22] = '{
        32'h0202_0300, 32'h0000_0001, 32'h0000_0000, 32'h0000_0002, 32'h0208_ff00, 32'h0207_ff00,
        32'h0107_0000, 32'h0108_0000, 32'h0000_0000, 32'h0107_0000, 32'h0204_0400, 32'h0202_0400,
        32'h0000_0004, 32'h0000_0000, 32'h0109_0000, 32'h0000_0000, 32'h0107_0000, 32'h0205_0600,
        32'h0205_0200, 32'h0000_0000, 32'h0205_ff00, 32'h0105_0000};

    pcic_port_change_irq #(.IS_SPI(1'b0)) pcic_port_change_irq_i (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_req(req), .i_pin_level(pin), .i_pin_is_input(inp),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_irq_out(o_irq_out), .o_irq_oe_n(o_irq_oe_n),
        .o_weak_pullup_en(o_weak_pullup_en), .o_auto_increment_off(o_auto_increment_off),
        .o_sda_edge_limit_on(o_sda_edge_limit_on), .o_address_pin_enable(o_address_pin_enable));

    // Second instance exercises the address-pin control of the SPI variant
    pcic_port_change_irq #(.IS_SPI(1'b1)) pcic_port_change_irq_spi_i (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_req(req), .i_pin_level(pin), .i_pin_is_input(inp),
        .o_reg_rdata(), .o_reg_rvalid(), .o_irq_out(), .o_irq_oe_n(), .o_weak_pullup_en(),
        .o_auto_increment_off(), .o_sda_edge_limit_on(), .o_address_pin_enable(spi_addr_pin_en));

    pcic_host_model pcic_host_model_i (.i_clk(i_clk), .o_req(req));

    initial i_clk = 1'b0;
    always #2.5 i_clk = ~i_clk;

    // Reference model of flags, capture and the register file
    assign cond = m_en & inp & ((m_sel & (pin ^ m_ref)) | (~m_sel & (pin ^ m_prev)));
    assign upd  = ~(m_en & inp & ~m_sel) | cond;
    assign clr  = req.rd && (req.addr == `PCIC_OFS_CAPTURE || req.addr == `PCIC_OFS_PORT);

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            {m_en, m_ref, m_sel, m_bias, m_flags, m_cap, m_prev, m_rdata, m_pu} <= '0;
            {m_cfg, m_rv, m_iout, m_ioe} <= 8'h01;
        end else begin
            m_flags <= (clr ? 8'h00 : m_flags) | cond;
            if (cond != 8'h00 && (m_flags == 8'h00 || clr)) begin
                m_cap <= pin;
            end
            m_prev <= (upd & pin) | (~upd & m_prev);
            m_pu   <= m_bias & inp;
            m_iout <= ~m_cfg[1] & ((m_flags != 8'h00) ~^ m_cfg[0]);
            m_ioe  <= m_cfg[1] & (m_flags == 8'h00);
            m_rv   <= req.rd;
            if (req.rd) begin
                case (req.addr)
                    `PCIC_OFS_IRQ_ENABLE: m_rdata <= m_en;
                    `PCIC_OFS_REFERENCE:  m_rdata <= m_ref;
                    `PCIC_OFS_SOURCE_SEL: m_rdata <= m_sel;
                    `PCIC_OFS_CONFIG:     m_rdata <= {2'b00, m_cfg, 1'b0};
                    `PCIC_OFS_WEAK_BIAS:  m_rdata <= m_bias;
                    `PCIC_OFS_IRQ_FLAGS:  m_rdata <= m_flags;
                    `PCIC_OFS_CAPTURE:    m_rdata <= m_cap;
                    default:              m_rdata <= 8'h00;
                endcase
            end
            if (req.wr) begin
                case (req.addr)
                    `PCIC_OFS_IRQ_ENABLE: m_en <= req.wdata;
                    `PCIC_OFS_REFERENCE:  m_ref <= req.wdata;
                    `PCIC_OFS_SOURCE_SEL: m_sel <= req.wdata;
                    `PCIC_OFS_CONFIG:     m_cfg <= req.wdata[5:1];
                    `PCIC_OFS_WEAK_BIAS:  m_bias <= req.wdata;
                    default:              ;
                endcase
            end
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step(input logic [31:0] op);
        pcic_host_model_i.xfer(op[25], op[24], op[23:16], op[15:8]);
        pin <= pin ^ op[7:0];
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(negedge i_clk) begin
        if (!i_sys_rst) begin
            chk(o_reg_rdata, m_rdata);
            chk({7'h00, o_reg_rvalid}, {7'h00, m_rv});
            chk({7'h00, spi_addr_pin_en}, {7'h00, m_cfg[2]});
            chk(o_weak_pullup_en, m_pu);
            chk({5'h00, o_irq_out, o_irq_oe_n, o_address_pin_enable}, {5'h00, m_iout, m_ioe, 1'b1});
            chk({6'h00, o_auto_increment_off, o_sda_edge_limit_on}, {6'h00, m_cfg[4], ~m_cfg[3]});
        end
    end

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        logic [31:0] op;
        i_sys_rst = 1'b1;
        pin = 8'h00;
        inp = 8'hff;
        seed = 32'h0000_d565;
        miscompares = 0;
        num_checks = 0;
        repeat (20) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            step({8'h01, a[7:0], 16'h0000});
        end
        foreach (DIR[k]) begin
            step(DIR[k]);
        end
        // Random traffic, occasional pin and direction changes
        for (int n = 0; n < 6000; n++) begin
            seed = lfsr_next(seed);
            op = seed;
            op[25] = op[25] & ~op[24];
            op[23:16] = {4'h0, op[19:16]};
            if (op[31:29] != 3'h0) begin
                op[7:0] = 8'h00;
            end
            if (op[31:27] == 5'h1f) begin
                inp <= op[15:8] | 8'h0f;
            end
            step(op);
        end
        // Idle cycles so the last request's answer is compared
        step(32'h0000_0000);
        step(32'h0000_0000);
        test_done();
    end
endmodule

`default_nettype wire
